// File: hw/masp_consts.vh
`ifndef MASP_CONSTS_VH
`define MASP_CONSTS_VH
`define MASP_ST_IDLE 5'h01
`define MASP_ST_CORR 5'h02
`define MASP_ST_GAIN 5'h04
`define MASP_ST_CORD 5'h08
`define MASP_ST_PUB 5'h10
`define MASP_CFG_MODE 2:0
`define MASP_CFG_COMBO 3
`define MASP_CFG_MOD 5:4
`define MASP_MODE_S1 3'h1
`define MASP_MODE_S2 3'h2
`define MASP_MODE_S3 3'h3
`define MASP_MODE_3D 3'h5
`define MASP_MOD_360 2'h0
`define MASP_MOD_90 2'h1
`define MASP_MOD_120 2'h2
`define MASP_MOD_180 2'h3
`define MASP_AMP_SHIFT 15
`define MASP_PH_SHIFT 4'hF
`define MASP_GAIN_SHIFT 4'hE
`define MASP_SP_SHIFT 4'hA
`define MASP_K_SHIFT 15
`define MASP_CORD_ITERS 5'h10
`define MASP_HALF_TURN 16'h8000
`define MASP_THIRD_TURN 16'h5555
`define MASP_TWO_THIRD 16'hAAAA
`define MASP_K_GAIN 17'h04DBA
`define MASP_TST_VEC 20'h02000
`define MASP_TST_ANGLE 16'h2000
`define MASP_TST_TOL 16'h0004
`define MASP_SAT_MAX 16'h7FFF
`define MASP_SAT_MIN 16'h8000
`define MASP_D0_AMP_LOW 0
`define MASP_D0_AMP_HIGH 1
`define MASP_D0_MODE_BAD 2
`define MASP_D0_SELFTEST 3
`define MASP_D1_OVERRUN 0
`define MASP_D1_SAT 1
`endif

// File: hw/masp_signal_path.v
// Operation
// - Amplitude: sum of squares over 32768
// - Two read-only 16-bit production words
// - Production words sent when serial enabled
// - Linear mode: atan2 of dZ over dX
// - Off-axis mode: atan2 of dY over dX
// - Setup one: 180 degree, four-pole magnet
// - Setup two: 360 degree, two-pole magnet
// - Setup three picks XZ or XY differences
// - Secondary angle only in 3D mode
// - Modulo on primary angle only
// - Filtered tap on primary channel only
// - Angle inputs carry phase, gain, offset
// - Power-up self-test, continuous checks, two words
// - Phase-correct channels two, three against one
// - Reference angle shifts zero, tapped
// - Setpoint-scaled angle tapped per channel
// - Compensated junction temperature tap
// - Amplitude limit check flags error
`include "masp_consts.vh"
module masp_signal_path #(
    parameter [15:0] PROD_INFO_1 = 16'h1A2B, // Arbitrary value
    parameter [15:0] PROD_INFO_2 = 16'h3C4D  // Arbitrary value
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_sample_valid,
    input wire [15:0] i_junction_temp_value,
    input wire signed [15:0] i_factory_corrected_field_ch1,
    input wire signed [15:0] i_factory_corrected_field_ch2,
    input wire signed [15:0] i_factory_corrected_field_ch3,
    input wire signed [15:0] i_cell4_field_x,
    input wire signed [15:0] i_cell4_field_y,
    input wire signed [15:0] i_cell4_field_z,
    input wire [15:0] i_measurement_mode_config,
    input wire signed [15:0] i_phase_shift_settings_ch2,
    input wire signed [15:0] i_phase_shift_settings_ch3,
    input wire signed [15:0] i_gain_ch1,
    input wire signed [15:0] i_gain_ch2,
    input wire signed [15:0] i_gain_ch3,
    input wire signed [15:0] i_offset_ch1,
    input wire signed [15:0] i_offset_ch2,
    input wire signed [15:0] i_offset_ch3,
    input wire [15:0] i_ref_angle_ch1,
    input wire [15:0] i_ref_angle_ch2,
    input wire signed [15:0] i_sp_gain_ch1,
    input wire signed [15:0] i_sp_gain_ch2,
    input wire signed [15:0] i_sp_offset_ch1,
    input wire signed [15:0] i_sp_offset_ch2,
    input wire [3:0] i_filter_shift,
    input wire [15:0] i_mag_low_limit,
    input wire [15:0] i_mag_high_limit,
    input wire i_serial_msg_en,
    output wire o_sample_ready,
    output reg o_taps_valid,
    output reg [15:0] o_junction_temp_value,
    output reg [15:0] o_factory_corrected_field_ch1,
    output reg [15:0] o_factory_corrected_field_ch2,
    output reg [15:0] o_factory_corrected_field_ch3,
    output reg [17:0] o_phase_fixed_field_ch2,
    output reg [17:0] o_phase_fixed_field_ch3,
    output reg [17:0] o_user_corrected_field_ch1,
    output reg [17:0] o_user_corrected_field_ch2,
    output reg [17:0] o_user_corrected_field_ch3,
    output reg [18:0] o_field_amplitude,
    output reg [15:0] o_primary_angle,
    output reg [15:0] o_secondary_angle,
    output reg [19:0] o_primary_field_strength,
    output reg [19:0] o_secondary_field_strength,
    output reg [15:0] o_ref_angle_ch1,
    output reg [15:0] o_ref_angle_ch2,
    output reg [15:0] o_modulo_angle,
    output reg [15:0] o_setpoint_in_ch1,
    output reg [15:0] o_setpoint_in_ch2,
    output reg [15:0] o_noise_filtered_position,
    output reg [15:0] o_fault_report_word0,
    output reg [15:0] o_fault_report_word1,
    output wire [15:0] o_production_info_word_1,
    output wire [15:0] o_production_info_word_2,
    output reg o_serial_msg_valid,
    output reg [15:0] o_serial_msg_word,
    output reg o_serial_msg_index
);

    function signed [17:0] masp_mul;
        input signed [17:0] a;
        input signed [15:0] b;
        input [3:0] sh;
        reg signed [33:0] p;
        begin
            p = a * b;
            p = p >>> sh;
            masp_mul = p[17:0];
        end
    endfunction

    function [16:0] masp_sq;
        input signed [15:0] v;
        reg signed [31:0] p;
        begin
            p = v * v;
            masp_sq = p[`MASP_AMP_SHIFT+16:`MASP_AMP_SHIFT];
        end
    endfunction

    function [15:0] masp_sat16;
        input signed [17:0] v;
        begin
            if (v > $signed({2'b00, `MASP_SAT_MAX}))
                masp_sat16 = `MASP_SAT_MAX;
            else if (v < $signed({2'b11, `MASP_SAT_MIN}))
                masp_sat16 = `MASP_SAT_MIN;
            else
                masp_sat16 = v[15:0];
        end
    endfunction

    function [15:0] masp_atan;
        input [3:0] i;
        begin
            case (i)
                4'h0: masp_atan = 16'h2000;
                4'h1: masp_atan = 16'h12E4;
                4'h2: masp_atan = 16'h09FB;
                4'h3: masp_atan = 16'h0511;
                4'h4: masp_atan = 16'h028B;
                4'h5: masp_atan = 16'h0146;
                4'h6: masp_atan = 16'h00A3;
                4'h7: masp_atan = 16'h0051;
                4'h8: masp_atan = 16'h0029;
                4'h9: masp_atan = 16'h0014;
                4'hA: masp_atan = 16'h000A;
                4'hB: masp_atan = 16'h0005;
                4'hC: masp_atan = 16'h0003;
                4'hD: masp_atan = 16'h0001;
                4'hE: masp_atan = 16'h0001;
                default: masp_atan = 16'h0000;
            endcase
        end
    endfunction

    // Sub-range folding; 120 degree steps need a reduction before scaling
    function [15:0] masp_modulo;
        input [15:0] a;
        input [1:0] sel;
        reg [15:0] r;
        reg [17:0] t;
        begin
            r = a;
            if (a >= `MASP_TWO_THIRD)
                r = a - `MASP_TWO_THIRD;
            else if (a >= `MASP_THIRD_TURN)
                r = a - `MASP_THIRD_TURN;
            t = {2'b00, r} + {1'b0, r, 1'b0};
            case (sel)
                `MASP_MOD_90: masp_modulo = {a[13:0], 2'b00};
                `MASP_MOD_120: masp_modulo = t[15:0];
                `MASP_MOD_180: masp_modulo = {a[14:0], 1'b0};
                default: masp_modulo = a;
            endcase
        end
    endfunction

    reg [4:0] state_reg;
    reg selftest_reg;
    reg selftest_fail_reg;
    reg pass2_reg;
    reg overrun_reg;
    reg [4:0] cnt_reg;
    reg [15:0] cfg_reg;
    reg [15:0] temp_reg;
    reg signed [15:0] fac1_reg;
    reg signed [15:0] fac2_reg;
    reg signed [15:0] fac3_reg;
    reg [18:0] amp_reg;
    reg signed [17:0] ld1_reg;
    reg signed [17:0] ld2_reg;
    reg signed [17:0] ld3_reg;
    reg signed [17:0] ph2_reg;
    reg signed [17:0] ph3_reg;
    reg signed [17:0] us1_reg;
    reg signed [17:0] us2_reg;
    reg signed [17:0] us3_reg;
    reg signed [19:0] cx_reg;
    reg signed [19:0] cy_reg;
    reg [15:0] cz_reg;
    reg [15:0] an1_reg;
    reg [15:0] an2_reg;
    reg [19:0] mg1_reg;
    reg [19:0] mg2_reg;

    wire [2:0] in_mode = i_measurement_mode_config[`MASP_CFG_MODE];
    wire [2:0] mode = cfg_reg[`MASP_CFG_MODE];
    wire is_3d = (mode == `MASP_MODE_3D);
    wire mode_bad = !(is_3d || mode == `MASP_MODE_S1 || mode == `MASP_MODE_S2 ||
                      mode == `MASP_MODE_S3);
    wire [18:0] amp_next = {2'b00, masp_sq(i_factory_corrected_field_ch1)} +
                           {2'b00, masp_sq(i_factory_corrected_field_ch2)} +
                           ((in_mode == `MASP_MODE_3D) ?
                            {2'b00, masp_sq(i_factory_corrected_field_ch3)} : 19'h0);

    // Customer gain and offset after phase fix
    wire signed [17:0] us1_next = masp_mul(ld1_reg, i_gain_ch1, `MASP_GAIN_SHIFT) +
                                  {{2{i_offset_ch1[15]}}, i_offset_ch1};
    wire signed [17:0] us2_next = masp_mul(ph2_reg, i_gain_ch2, `MASP_GAIN_SHIFT) +
                                  {{2{i_offset_ch2[15]}}, i_offset_ch2};
    wire signed [17:0] us3_next = masp_mul(ph3_reg, i_gain_ch3, `MASP_GAIN_SHIFT) +
                                  {{2{i_offset_ch3[15]}}, i_offset_ch3};

    // Vector pair for the angle engine: primary from fresh values, secondary from stored
    reg signed [17:0] sel_x;
    reg signed [17:0] sel_y;
    always @* begin
        if (state_reg == `MASP_ST_GAIN) begin
            sel_x = us1_next;
            sel_y = is_3d ? us3_next : us2_next;
        end else begin
            sel_x = us2_reg;
            sel_y = us3_reg;
        end
    end
    wire sel_neg = sel_x[17];
    wire signed [19:0] init_x = sel_neg ? -{{2{sel_x[17]}}, sel_x} : {{2{sel_x[17]}}, sel_x};
    wire signed [19:0] init_y = sel_neg ? -{{2{sel_y[17]}}, sel_y} : {{2{sel_y[17]}}, sel_y};
    wire [15:0] init_z = sel_neg ? `MASP_HALF_TURN : 16'h0000;

    wire signed [19:0] shx = cx_reg >>> cnt_reg[3:0];
    wire signed [19:0] shy = cy_reg >>> cnt_reg[3:0];
    wire [15:0] step_z = masp_atan(cnt_reg[3:0]);
    wire signed [36:0] mag_prod = cx_reg * $signed(`MASP_K_GAIN);
    wire [19:0] mag_now = mag_prod[`MASP_K_SHIFT+19:`MASP_K_SHIFT];
    wire [15:0] tst_err = (cz_reg > `MASP_TST_ANGLE) ? cz_reg - `MASP_TST_ANGLE :
                          `MASP_TST_ANGLE - cz_reg;

    // Post-angle chain, evaluated for the publish cycle
    wire [15:0] ref1 = an1_reg - i_ref_angle_ch1;
    wire [15:0] ref2 = is_3d ? an2_reg - i_ref_angle_ch2 : 16'h0000;
    wire [15:0] mod1 = masp_modulo(ref1, cfg_reg[`MASP_CFG_MOD]);
    wire signed [17:0] spr1 = masp_mul({{3{~mod1[15]}}, mod1[14:0]},
                                       i_sp_gain_ch1, `MASP_SP_SHIFT) +
                              {{2{i_sp_offset_ch1[15]}}, i_sp_offset_ch1};
    wire signed [17:0] spr2 = masp_mul({{3{~ref2[15]}}, ref2[14:0]},
                                       i_sp_gain_ch2, `MASP_SP_SHIFT) +
                              {{2{i_sp_offset_ch2[15]}}, i_sp_offset_ch2};
    wire [15:0] sp1 = masp_sat16(spr1);
    wire [15:0] sp2 = is_3d ? masp_sat16(spr2) : 16'h0000;
    wire sp_sat = (sp1 != spr1[15:0]) || (is_3d && sp2 != spr2[15:0]);
    wire signed [16:0] flt_diff = {sp1[15], sp1} - {o_noise_filtered_position[15],
                                                     o_noise_filtered_position};
    wire signed [16:0] flt_step = flt_diff >>> i_filter_shift;
    wire [15:0] flt_next = (i_filter_shift == 4'h0) ? sp1 :
                           o_noise_filtered_position + flt_step[15:0];
    wire amp_lo = amp_reg < {3'b000, i_mag_low_limit};
    wire amp_hi = amp_reg > {3'b000, i_mag_high_limit};

    reg [15:0] diag0;
    reg [15:0] diag1;
    always @* begin
        diag0 = 16'h0000;
        diag1 = 16'h0000;
        diag0[`MASP_D0_AMP_LOW] = amp_lo;
        diag0[`MASP_D0_AMP_HIGH] = amp_hi;
        diag0[`MASP_D0_MODE_BAD] = mode_bad;
        diag0[`MASP_D0_SELFTEST] = selftest_fail_reg;
        diag1[`MASP_D1_OVERRUN] = overrun_reg;
        diag1[`MASP_D1_SAT] = sp_sat;
    end

    assign o_sample_ready = (state_reg == `MASP_ST_IDLE);
    assign o_production_info_word_1 = PROD_INFO_1;
    assign o_production_info_word_2 = PROD_INFO_2;

    // Reset lands in the angle engine on a fixed 45 degree vector: power-up self-test
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= `MASP_ST_CORD;
            selftest_reg <= 1'b1;
            selftest_fail_reg <= 1'b0;
            pass2_reg <= 1'b0;
            overrun_reg <= 1'b0;
            cnt_reg <= 5'h00;
            cfg_reg <= 16'h0000;
            temp_reg <= 16'h0000;
            fac1_reg <= 16'h0000;
            fac2_reg <= 16'h0000;
            fac3_reg <= 16'h0000;
            amp_reg <= 19'h00000;
            ld1_reg <= 18'h00000;
            ld2_reg <= 18'h00000;
            ld3_reg <= 18'h00000;
            ph2_reg <= 18'h00000;
            ph3_reg <= 18'h00000;
            us1_reg <= 18'h00000;
            us2_reg <= 18'h00000;
            us3_reg <= 18'h00000;
            cx_reg <= `MASP_TST_VEC;
            cy_reg <= `MASP_TST_VEC;
            cz_reg <= 16'h0000;
            an1_reg <= 16'h0000;
            an2_reg <= 16'h0000;
            mg1_reg <= 20'h00000;
            mg2_reg <= 20'h00000;
            o_taps_valid <= 1'b0;
            o_junction_temp_value <= 16'h0000;
            o_factory_corrected_field_ch1 <= 16'h0000;
            o_factory_corrected_field_ch2 <= 16'h0000;
            o_factory_corrected_field_ch3 <= 16'h0000;
            o_phase_fixed_field_ch2 <= 18'h00000;
            o_phase_fixed_field_ch3 <= 18'h00000;
            o_user_corrected_field_ch1 <= 18'h00000;
            o_user_corrected_field_ch2 <= 18'h00000;
            o_user_corrected_field_ch3 <= 18'h00000;
            o_field_amplitude <= 19'h00000;
            o_primary_angle <= 16'h0000;
            o_secondary_angle <= 16'h0000;
            o_primary_field_strength <= 20'h00000;
            o_secondary_field_strength <= 20'h00000;
            o_ref_angle_ch1 <= 16'h0000;
            o_ref_angle_ch2 <= 16'h0000;
            o_modulo_angle <= 16'h0000;
            o_setpoint_in_ch1 <= 16'h0000;
            o_setpoint_in_ch2 <= 16'h0000;
            o_noise_filtered_position <= 16'h0000;
            o_fault_report_word0 <= 16'h0000;
            o_fault_report_word1 <= 16'h0000;
            o_serial_msg_valid <= 1'b0;
            o_serial_msg_word <= 16'h0000;
            o_serial_msg_index <= 1'b0;
        end else begin
            o_taps_valid <= 1'b0;
            o_serial_msg_valid <= 1'b0;
            // A sample offered while busy is dropped and remembered
            if (i_sample_valid && state_reg != `MASP_ST_IDLE)
                overrun_reg <= 1'b1;
            case (state_reg)
                `MASP_ST_IDLE: begin
                    if (i_sample_valid) begin
                        cfg_reg <= i_measurement_mode_config;
                        temp_reg <= i_junction_temp_value;
                        fac1_reg <= i_factory_corrected_field_ch1;
                        fac2_reg <= i_factory_corrected_field_ch2;
                        fac3_reg <= i_factory_corrected_field_ch3;
                        amp_reg <= amp_next;
                        if (in_mode == `MASP_MODE_S3) begin
                            // Cell differences cancel a homogeneous stray field
                            ld1_reg <= {{2{i_cell4_field_x[15]}}, i_cell4_field_x} -
                                       {{2{i_factory_corrected_field_ch1[15]}},
                                        i_factory_corrected_field_ch1};
                            if (i_measurement_mode_config[`MASP_CFG_COMBO])
                                ld2_reg <= {{2{i_cell4_field_y[15]}}, i_cell4_field_y} -
                                           {{2{i_factory_corrected_field_ch2[15]}},
                                            i_factory_corrected_field_ch2};
                            else
                                ld2_reg <= {{2{i_cell4_field_z[15]}}, i_cell4_field_z} -
                                           {{2{i_factory_corrected_field_ch3[15]}},
                                            i_factory_corrected_field_ch3};
                            ld3_reg <= 18'h00000;
                        end else begin
                            // Setup one: full code span covers 180 degrees of a 4-pole magnet
                            ld1_reg <= {{2{i_factory_corrected_field_ch1[15]}},
                                        i_factory_corrected_field_ch1};
                            ld2_reg <= {{2{i_factory_corrected_field_ch2[15]}},
                                        i_factory_corrected_field_ch2};
                            ld3_reg <= {{2{i_factory_corrected_field_ch3[15]}},
                                        i_factory_corrected_field_ch3};
                        end
                        state_reg <= `MASP_ST_CORR;
                    end
                end
                `MASP_ST_CORR: begin
                    ph2_reg <= ld2_reg - masp_mul(ld1_reg, i_phase_shift_settings_ch2,
                                                  `MASP_PH_SHIFT);
                    ph3_reg <= ld3_reg - masp_mul(ld1_reg, i_phase_shift_settings_ch3,
                                                  `MASP_PH_SHIFT);
                    state_reg <= `MASP_ST_GAIN;
                end
                `MASP_ST_GAIN: begin
                    us1_reg <= us1_next;
                    us2_reg <= us2_next;
                    us3_reg <= us3_next;
                    cx_reg <= init_x;
                    cy_reg <= init_y;
                    cz_reg <= init_z;
                    cnt_reg <= 5'h00;
                    pass2_reg <= 1'b0;
                    state_reg <= `MASP_ST_CORD;
                end
                `MASP_ST_CORD: begin
                    if (cnt_reg != `MASP_CORD_ITERS) begin
                        if (!cy_reg[19]) begin
                            cx_reg <= cx_reg + shy;
                            cy_reg <= cy_reg - shx;
                            cz_reg <= cz_reg + step_z;
                        end else begin
                            cx_reg <= cx_reg - shy;
                            cy_reg <= cy_reg + shx;
                            cz_reg <= cz_reg - step_z;
                        end
                        cnt_reg <= cnt_reg + 5'h01;
                    end else if (selftest_reg) begin
                        selftest_reg <= 1'b0;
                        selftest_fail_reg <= (tst_err > `MASP_TST_TOL);
                        o_fault_report_word0[`MASP_D0_SELFTEST] <=
                            (tst_err > `MASP_TST_TOL);
                        state_reg <= `MASP_ST_IDLE;
                    end else if (!pass2_reg) begin
                        an1_reg <= cz_reg;
                        mg1_reg <= mag_now;
                        if (is_3d) begin
                            pass2_reg <= 1'b1;
                            cx_reg <= init_x;
                            cy_reg <= init_y;
                            cz_reg <= init_z;
                            cnt_reg <= 5'h00;
                        end else begin
                            an2_reg <= 16'h0000;
                            mg2_reg <= 20'h00000;
                            state_reg <= `MASP_ST_PUB;
                        end
                    end else begin
                        an2_reg <= cz_reg;
                        mg2_reg <= mag_now;
                        state_reg <= `MASP_ST_PUB;
                    end
                end
                `MASP_ST_PUB: begin
                    // Every tap loads here in one edge, so reads never mix samples
                    o_taps_valid <= 1'b1;
                    o_junction_temp_value <= temp_reg;
                    o_factory_corrected_field_ch1 <= fac1_reg;
                    o_factory_corrected_field_ch2 <= fac2_reg;
                    o_factory_corrected_field_ch3 <= fac3_reg;
                    o_phase_fixed_field_ch2 <= ph2_reg;
                    o_phase_fixed_field_ch3 <= ph3_reg;
                    o_user_corrected_field_ch1 <= us1_reg;
                    o_user_corrected_field_ch2 <= us2_reg;
                    o_user_corrected_field_ch3 <= us3_reg;
                    o_field_amplitude <= amp_reg;
                    o_primary_angle <= an1_reg;
                    o_secondary_angle <= an2_reg;
                    o_primary_field_strength <= mg1_reg;
                    o_secondary_field_strength <= mg2_reg;
                    o_ref_angle_ch1 <= ref1;
                    o_ref_angle_ch2 <= ref2;
                    o_modulo_angle <= mod1;
                    o_setpoint_in_ch1 <= sp1;
                    o_setpoint_in_ch2 <= sp2;
                    o_noise_filtered_position <= flt_next;
                    o_fault_report_word0 <= diag0;
                    o_fault_report_word1 <= diag1;
                    if (i_serial_msg_en) begin
                        o_serial_msg_valid <= 1'b1;
                        o_serial_msg_word <= o_serial_msg_index ? PROD_INFO_2 :
                                             PROD_INFO_1;
                        o_serial_msg_index <= ~o_serial_msg_index;
                    end
                    state_reg <= `MASP_ST_IDLE;
                end
                default: state_reg <= `MASP_ST_IDLE;
            endcase
        end
    end

endmodule // masp_signal_path

// File: tb/masp_front_model.sv
module masp_front_model (
    input wire i_clk_sys,
    input wire i_ready,
    input wire i_go,
    input wire [47:0] i_fields,
    output logic o_valid,
    output wire [47:0] o_fields
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_valid = 1'h0;
    // Inverted when idle so stale data never passes as new
    assign o_fields = o_valid ? i_fields : ~i_fields;
    always @(posedge i_clk_sys) o_valid <= i_go || (o_valid && !i_ready);
endmodule // masp_front_model

// File: tb/masp_sva.sv
module masp_sva (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_sample_valid,
    input wire i_serial_msg_en,
    input wire o_sample_ready,
    input wire o_taps_valid,
    input wire o_serial_msg_valid,
    input wire o_serial_msg_index
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence s_take; i_sample_valid && o_sample_ready; endsequence
    a_tap_delay: assert property (s_take |-> ##21 o_taps_valid or ##38 o_taps_valid)
        else $error("late");
    a_busy_take: assert property (s_take |=> !o_sample_ready [*8]) else $error("busy");
    a_quiet_take: assert property (s_take |=> !o_taps_valid [*8]) else $error("early");
    a_taps_pulse: assert property (o_taps_valid |=> !o_taps_valid) else $error("long");
    a_ready_back: assert property (o_taps_valid |-> o_sample_ready) else $error("stuck");
    a_fall_cause: assert property ($fell(o_sample_ready) |-> $past(i_sample_valid))
        else $error("drop");
    a_serial_gate: assert property (o_serial_msg_valid == (o_taps_valid && $past(i_serial_msg_en)))
        else $error("gate");
    a_index_turn: assert property (o_serial_msg_valid == $changed(o_serial_msg_index))
        else $error("index");
endmodule // masp_sva
bind masp_signal_path masp_sva u_sva (.*);

// File: tb/test_magnetic_angle_signal_path.sv
module test_magnetic_angle_signal_path;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [15:0] W1 = 16'h5A11; // Arbitrary value
    localparam [15:0] W2 = 16'h6B22; // Arbitrary value
    logic i_clk_sys = 1'h0, i_nrst = 1'h0, go = 1'h0, en = 1'h1;
    logic [15:0] cfg = 16'h0000, z = 16'h0000, g = 16'h4000, lo = 16'h1000, hi = 16'h3000;
    logic [47:0] fld = 48'h0;
    wire vld, rdy, tv, si;
    wire [47:0] f;
    wire [18:0] amp;
    wire [15:0] jt, a1, a2, w0, w1, p1, p2, sw, sp, nf;
    int failures = 0, samples_checked = 0;
    initial forever #10 i_clk_sys = ~i_clk_sys;
    masp_front_model u_front (.i_clk_sys, .i_ready(rdy), .i_go(go), .i_fields(fld),
        .o_valid(vld), .o_fields(f));
    masp_signal_path #(.PROD_INFO_1(W1), .PROD_INFO_2(W2)) u_dut (.i_clk_sys, .i_nrst,
        .i_sample_valid(vld),
        .i_junction_temp_value(lo), .i_factory_corrected_field_ch1(f[15:0]),
        .i_factory_corrected_field_ch2(f[31:16]), .i_factory_corrected_field_ch3(f[47:32]),
        .i_cell4_field_x(z), .i_cell4_field_y(z), .i_cell4_field_z(z),
        .i_measurement_mode_config(cfg), .i_phase_shift_settings_ch2(z),
        .i_phase_shift_settings_ch3(z), .i_gain_ch1(g), .i_gain_ch2(g), .i_gain_ch3(g),
        .i_offset_ch1(z), .i_offset_ch2(z), .i_offset_ch3(z), .i_ref_angle_ch1(z),
        .i_ref_angle_ch2(z), .i_sp_gain_ch1(g), .i_sp_gain_ch2(g), .i_sp_offset_ch1(z),
        .i_sp_offset_ch2(z), .i_filter_shift(z[3:0]), .i_mag_low_limit(lo),
        .i_mag_high_limit(hi), .i_serial_msg_en(en), .o_sample_ready(rdy), .o_taps_valid(tv),
        .o_junction_temp_value(jt), .o_factory_corrected_field_ch1(),
        .o_factory_corrected_field_ch2(), .o_factory_corrected_field_ch3(),
        .o_phase_fixed_field_ch2(), .o_phase_fixed_field_ch3(), .o_user_corrected_field_ch1(),
        .o_user_corrected_field_ch2(), .o_user_corrected_field_ch3(), .o_field_amplitude(amp),
        .o_primary_angle(a1), .o_secondary_angle(a2), .o_primary_field_strength(),
        .o_secondary_field_strength(), .o_ref_angle_ch1(), .o_ref_angle_ch2(),
        .o_modulo_angle(), .o_setpoint_in_ch1(sp), .o_setpoint_in_ch2(),
        .o_noise_filtered_position(nf), .o_fault_report_word0(w0), .o_fault_report_word1(w1),
        .o_production_info_word_1(p1), .o_production_info_word_2(p2), .o_serial_msg_valid(),
        .o_serial_msg_word(sw), .o_serial_msg_index(si));
    task results;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input [19:0] a, input [19:0] b);
        samples_checked++;
        if (a !== b) begin
            failures++;
            $display("BAD %0t %h %h", $time, a, b);
        end
    endtask
    task smp(input [15:0] c, input [47:0] v);
        int n;
        n = 0;
        // A sample offered while busy is dropped, so wait for idle first
        while (n < 80 && rdy !== 1'h1) begin
            n++;
            @(negedge i_clk_sys);
        end
        cfg = c;
        fld = v;
        go = 1'h1;
        @(negedge i_clk_sys) go = 1'h0;
        while (n < 160 && tv !== 1'h1) begin
            n++;
            @(negedge i_clk_sys);
        end
        if (n == 160) begin
            failures++;
            results;
        end
    endtask
    initial begin
        repeat (12) @(negedge i_clk_sys);
        i_nrst = 1'h1;
        smp(16'h0002, 48'h4000);
        chk(amp, 20'h02000);
        chk({a2, w0[3:0]}, 20'h00000);
        chk(jt, lo);
        chk(p1, W1);
        chk({si, sw}, {1'h1, W1});
        smp(16'h0005, 48'h400040004000);
        chk({amp, w0[1]}, 20'h0C001);
        chk(16'(a1 - 16'h1FFC) <= 16'h0008, 20'h00001);
        chk(16'(a2 - 16'h1FFC) <= 16'h0008, 20'h00001);
        chk(sp, 16'h8000);
        chk(nf, 16'h8000);
        chk(w1[1:0], 2'h2);
        chk(p2, W2);
        chk({si, sw}, {1'h0, W2});
        smp(16'h000B, 48'h0000C000C000);
        chk(16'(a1 - 16'h1FFC) <= 16'h0008, 20'h00001);
        smp(16'h0003, 48'hC0000000C000);
        chk(16'(a1 - 16'h1FFC) <= 16'h0008, 20'h00001);
        en = 1'h0;
        smp(16'h0007, 48'h0100);
        chk(w0[2:0], 3'h5);
        chk({si, sw}, {1'h0, W2});
        results;
    end
endmodule // test_magnetic_angle_signal_path
